// ==== hdl/host_ctrl_set_clear_reg.sv ====
// control flag register pair with set and clear addresses and its effects
//
// Operation
// - one flag register seen at set address 50h and clear address 54h.
// - reset value is 0080_0000h, only the config permit flag set.
// - rom image valid enables answering config ROM block reads and atomic update.
// - rom image valid clear answers config ROM block reads with type error.
// - bus reset with rom image valid clear leaves ROM map registers unchanged.
// - rom image valid may be set only while link active is clear.
// - rom image valid cleared by system reset, self reset or fetch error.
// - bit 30 selects byte swapping of DMA data accesses.
// - delayed acknowledge flag makes the node answer packets with ack tardy.
// - every ack tardy sent raises the interrupt event bit 27 pulse.
// - reserved bits 28-24 and 21-20 read as zero.
// - config permit loads from EEPROM; software can only clear it.
// - link power flag permits or blocks all link to PHY traffic.
// - link active clear disconnects the node from the bus at once.
// - self reset resets state, flushes FIFOs, reads one until done.
// - bit 18 enables buffered writes; changed only while link inactive (the logic does not gate it on link active).
//
// Local design decision: strobed register access.
`default_nettype none
module host_ctrl_set_clear_reg #(
   parameter int RESET_CYCLES = host_ctrl_pkg::SELF_RESET_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [host_ctrl_pkg::ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output var logic [31:0] rdata_ff,
   input wire logic eeprom_load,
   input wire logic eeprom_permit,
   input wire logic fetch_error,
   input wire logic bus_reset,
   input wire logic req_valid,
   input wire logic req_rom_block,
   output var logic ack_valid_ff,
   output var logic [3:0] ack_code_ff,
   output var logic ack_tardy_event_ff,
   output var logic rom_regs_update_ff,
   output var logic rom_serve_en_ff,
   output var logic byte_swap_en_ff,
   output var logic phy_enhance_en_ff,
   output var logic link_phy_enable_ff,
   output var logic buffered_write_en_ff,
   output var logic link_connected_ff,
   output var logic flush_ff
);
   logic rom_image_valid_ff;
   logic swap_disable_ff;
   logic ack_delay_ff;
   logic phy_config_permit_ff;
   logic phy_enhance_on_ff;
   logic link_power_on_ff;
   logic buffered_write_on_ff;
   logic link_active_ff;
   logic self_reset_busy;
   logic set_wr;
   logic clr_wr;
   logic self_reset_start;
   logic [31:0] cur_flags;

   // plain flag update; set and clear never meet as strobes are exclusive
   function automatic logic sc_next(input logic cur, input logic s, input logic c);
      sc_next = s ? 1'b1 : (c ? 1'b0 : cur);
   endfunction

   // both addresses reach the same flops
   always_comb begin
      set_wr = wr_en && (addr == host_ctrl_pkg::FLAGS_SET_OFS);
      clr_wr = wr_en && (addr == host_ctrl_pkg::FLAGS_CLR_OFS);
      self_reset_start = set_wr && wdata[host_ctrl_pkg::SRST_BIT] && !self_reset_busy;
   end

   self_reset_seq #(
      .CYCLES(RESET_CYCLES)
   ) u_seq (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(self_reset_start),
      .busy_ff(self_reset_busy)
   );

   // a fetch error beats a software set in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_image_valid_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::ROM_VALID_BIT];
      end else if (self_reset_busy || fetch_error) begin
         rom_image_valid_ff <= 1'b0;
      end else begin
         rom_image_valid_ff <= sc_next(rom_image_valid_ff,
            set_wr && wdata[host_ctrl_pkg::ROM_VALID_BIT] && !link_active_ff,
            clr_wr && wdata[host_ctrl_pkg::ROM_VALID_BIT]);
      end
   end

   // ordinary set/clear flags, all back to reset during self reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         swap_disable_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::SWAP_DIS_BIT];
         ack_delay_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::ACK_DELAY_BIT];
         phy_enhance_on_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::ENHANCE_BIT];
         link_power_on_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::LPS_BIT];
         buffered_write_on_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::BUFW_BIT];
         link_active_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::LINK_BIT];
      end else if (self_reset_busy) begin
         swap_disable_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::SWAP_DIS_BIT];
         ack_delay_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::ACK_DELAY_BIT];
         phy_enhance_on_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::ENHANCE_BIT];
         link_power_on_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::LPS_BIT];
         buffered_write_on_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::BUFW_BIT];
         link_active_ff <= host_ctrl_pkg::FLAGS_RESET[host_ctrl_pkg::LINK_BIT];
      end else begin
         swap_disable_ff <= sc_next(swap_disable_ff,
            set_wr && wdata[host_ctrl_pkg::SWAP_DIS_BIT],
            clr_wr && wdata[host_ctrl_pkg::SWAP_DIS_BIT]);
         ack_delay_ff <= sc_next(ack_delay_ff,
            set_wr && wdata[host_ctrl_pkg::ACK_DELAY_BIT],
            clr_wr && wdata[host_ctrl_pkg::ACK_DELAY_BIT]);
         // no hardware gate: the driver owns the permit check
         phy_enhance_on_ff <= sc_next(phy_enhance_on_ff,
            set_wr && wdata[host_ctrl_pkg::ENHANCE_BIT],
            clr_wr && wdata[host_ctrl_pkg::ENHANCE_BIT]);
         link_power_on_ff <= sc_next(link_power_on_ff,
            set_wr && wdata[host_ctrl_pkg::LPS_BIT],
            clr_wr && wdata[host_ctrl_pkg::LPS_BIT]);
         buffered_write_on_ff <= sc_next(buffered_write_on_ff,
            set_wr && wdata[host_ctrl_pkg::BUFW_BIT],
            clr_wr && wdata[host_ctrl_pkg::BUFW_BIT]);
         link_active_ff <= sc_next(link_active_ff,
            set_wr && wdata[host_ctrl_pkg::LINK_BIT],
            clr_wr && wdata[host_ctrl_pkg::LINK_BIT]);
      end
   end

   // EEPROM load wins over a software clear; self reset keeps the strap
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phy_config_permit_ff <= host_ctrl_pkg::PERMIT_RESET;
      end else if (eeprom_load) begin
         phy_config_permit_ff <= eeprom_permit;
      end else if (clr_wr && wdata[host_ctrl_pkg::PERMIT_BIT]) begin
         phy_config_permit_ff <= 1'b0;
      end
   end

   // read image: reserved bits forced low
   always_comb begin
      cur_flags = '0;
      cur_flags[host_ctrl_pkg::ROM_VALID_BIT] = rom_image_valid_ff;
      cur_flags[host_ctrl_pkg::SWAP_DIS_BIT] = swap_disable_ff;
      cur_flags[host_ctrl_pkg::ACK_DELAY_BIT] = ack_delay_ff;
      cur_flags[host_ctrl_pkg::PERMIT_BIT] = phy_config_permit_ff;
      cur_flags[host_ctrl_pkg::ENHANCE_BIT] = phy_enhance_on_ff;
      cur_flags[host_ctrl_pkg::LPS_BIT] = link_power_on_ff;
      cur_flags[host_ctrl_pkg::BUFW_BIT] = buffered_write_on_ff;
      cur_flags[host_ctrl_pkg::LINK_BIT] = link_active_ff;
      cur_flags[host_ctrl_pkg::SRST_BIT] = self_reset_busy;
   end

   // unmapped reads return zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (rd_en && (addr == host_ctrl_pkg::FLAGS_SET_OFS ||
                             addr == host_ctrl_pkg::FLAGS_CLR_OFS)) begin
         rdata_ff <= cur_flags & host_ctrl_pkg::IMPL_MASK;
      end else begin
         rdata_ff <= '0;
      end
   end

   // acknowledge of an incoming packet, one edge after the request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_valid_ff <= 1'b0;
         ack_code_ff <= host_ctrl_pkg::ACK_COMPLETE;
         ack_tardy_event_ff <= 1'b0;
      end else if (!req_valid || !link_active_ff || self_reset_busy) begin
         // disconnected nodes stay silent
         ack_valid_ff <= 1'b0;
         ack_tardy_event_ff <= 1'b0;
      end else if (req_rom_block && !rom_image_valid_ff) begin
         ack_valid_ff <= 1'b1;
         ack_code_ff <= host_ctrl_pkg::ACK_TYPE_ERROR;
         ack_tardy_event_ff <= 1'b0;
      end else if (ack_delay_ff) begin
         // tardy for everything, self accesses included
         ack_valid_ff <= 1'b1;
         ack_code_ff <= host_ctrl_pkg::ACK_TARDY;
         ack_tardy_event_ff <= 1'b1;
      end else begin
         ack_valid_ff <= 1'b1;
         ack_code_ff <= host_ctrl_pkg::ACK_PENDING;
         ack_tardy_event_ff <= 1'b0;
      end
   end

   // ROM map registers reload only with a valid image
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_regs_update_ff <= 1'b0;
      end else begin
         rom_regs_update_ff <= bus_reset && rom_image_valid_ff;
      end
   end

   // steering outputs, one edge behind the flags
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_serve_en_ff <= 1'b0;
         byte_swap_en_ff <= 1'b1;
         phy_enhance_en_ff <= 1'b0;
         link_phy_enable_ff <= 1'b0;
         buffered_write_en_ff <= 1'b0;
         link_connected_ff <= 1'b0;
         flush_ff <= 1'b0;
      end else begin
         rom_serve_en_ff <= rom_image_valid_ff;
         byte_swap_en_ff <= !swap_disable_ff;
         phy_enhance_en_ff <= phy_enhance_on_ff;
         link_phy_enable_ff <= link_power_on_ff;
         buffered_write_en_ff <= buffered_write_on_ff;
         link_connected_ff <= link_active_ff && !self_reset_busy;
         flush_ff <= self_reset_busy;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence set_bit_s(int b);
      set_wr && wdata[b];
   endsequence

   sequence clr_bit_s(int b);
      clr_wr && wdata[b];
   endsequence

   rom_set_gate_a: assert property (
      set_bit_s(host_ctrl_pkg::ROM_VALID_BIT) ##0 (link_active_ff && !rom_image_valid_ff)
      |=> !rom_image_valid_ff)
      else $error("rom image valid set while link active");

   rom_set_ok_a: assert property (
      set_bit_s(host_ctrl_pkg::ROM_VALID_BIT) ##0 (!link_active_ff && !fetch_error &&
      !self_reset_busy) |=> rom_image_valid_ff)
      else $error("rom image valid set lost");

   fetch_clear_a: assert property (
      fetch_error |=> !rom_image_valid_ff)
      else $error("fetch error left rom image valid set");

   swap_clear_a: assert property (
      clr_bit_s(host_ctrl_pkg::SWAP_DIS_BIT) ##0 !self_reset_busy
      |=> !swap_disable_ff ##1 byte_swap_en_ff)
      else $error("swap disable clear not seen on swap enable");

   type_error_a: assert property (
      (req_valid && req_rom_block && !rom_image_valid_ff && link_active_ff && !self_reset_busy)
      |=> ack_valid_ff && ack_code_ff == host_ctrl_pkg::ACK_TYPE_ERROR)
      else $error("config rom read without image not refused");

   tardy_event_a: assert property (
      (ack_valid_ff && ack_code_ff == host_ctrl_pkg::ACK_TARDY) == ack_tardy_event_ff)
      else $error("tardy event and tardy ack disagree");

   tardy_all_a: assert property (
      (req_valid && !req_rom_block && ack_delay_ff && link_active_ff && !self_reset_busy)
      |=> ack_code_ff == host_ctrl_pkg::ACK_TARDY)
      else $error("delayed acknowledge not tardy");

   disconnect_a: assert property (
      (req_valid && !link_active_ff) |=> !ack_valid_ff)
      else $error("disconnected node acknowledged a packet");

   rom_map_hold_a: assert property (
      (bus_reset && !rom_image_valid_ff) |=> !rom_regs_update_ff)
      else $error("rom registers updated without valid image");

   permit_no_set_a: assert property (
      (set_bit_s(host_ctrl_pkg::PERMIT_BIT) ##0 (!phy_config_permit_ff && !eeprom_load))
      |=> !phy_config_permit_ff)
      else $error("software set the config permit flag");

   reserved_zero_a: assert property (
      rd_en |=> (rdata_ff & ~host_ctrl_pkg::IMPL_MASK) == 32'h0000_0000)
      else $error("reserved bits read nonzero");

   self_reset_a: assert property (
      self_reset_start |=> self_reset_busy [*2] ##0 !link_active_ff ##1 flush_ff)
      else $error("self reset not held busy");

   lps_follow_a: assert property (
      link_phy_enable_ff == $past(link_power_on_ff))
      else $error("link to phy enable does not follow link power");
endmodule
`default_nettype wire

// ==== hdl/host_ctrl_pkg.sv ====
// constants for the host controller control flag register pair
`default_nettype none
package host_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] FLAGS_SET_OFS = 8'h50;
   localparam logic [ADDR_W-1:0] FLAGS_CLR_OFS = 8'h54;
   localparam logic [31:0] FLAGS_RESET = 32'h0080_0000;
   localparam logic PERMIT_RESET = 1'h1;

   localparam int ROM_VALID_BIT = 31;
   localparam int SWAP_DIS_BIT = 30;
   localparam int ACK_DELAY_BIT = 29;
   localparam int PERMIT_BIT = 23;
   localparam int ENHANCE_BIT = 22;
   localparam int LPS_BIT = 19;
   localparam int BUFW_BIT = 18;
   localparam int LINK_BIT = 17;
   localparam int SRST_BIT = 16;
   // every bit that reads back anything; the rest read as zero
   localparam logic [31:0] IMPL_MASK = 32'hE0CF_0000;

   localparam int SELF_RESET_CYCLES = 16;

   localparam logic [3:0] ACK_COMPLETE = 4'h1;
   localparam logic [3:0] ACK_PENDING = 4'h2;
   localparam logic [3:0] ACK_TARDY = 4'hB;
   localparam logic [3:0] ACK_TYPE_ERROR = 4'hE;

   typedef enum logic {SEQ_IDLE, SEQ_BUSY} seq_state_t;
endpackage
`default_nettype wire

// ==== hdl/self_reset_seq.sv ====
// sequencer that holds the block in software reset for a fixed time
`default_nettype none
module self_reset_seq #(
   parameter int CYCLES = host_ctrl_pkg::SELF_RESET_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   output var logic busy_ff
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   host_ctrl_pkg::seq_state_t state_ff;
   logic [CW-1:0] cnt_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= host_ctrl_pkg::SEQ_IDLE;
         cnt_ff <= '0;
      end else begin
         case (state_ff)
            host_ctrl_pkg::SEQ_IDLE: begin
               cnt_ff <= '0;
               if (start) begin
                  state_ff <= host_ctrl_pkg::SEQ_BUSY;
               end
            end
            host_ctrl_pkg::SEQ_BUSY: begin
               cnt_ff <= cnt_ff + CW'(1);
               if (cnt_ff == LAST) begin
                  state_ff <= host_ctrl_pkg::SEQ_IDLE;
               end
            end
            default: state_ff <= host_ctrl_pkg::SEQ_IDLE;
         endcase
      end
   end

   // busy is the state itself, so it follows start by exactly one edge
   always_comb begin
      busy_ff = (state_ff == host_ctrl_pkg::SEQ_BUSY);
   end
endmodule
`default_nettype wire

// ==== sim/host_ctrl_set_clear_reg_tb.sv ====
// self-checking bench for the control flag set/clear register pair
`default_nettype none
module host_ctrl_set_clear_reg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST_CYC = 4;
   localparam logic [31:0] SET_M = 32'hE04E_0000;
   localparam logic [31:0] CLR_M = 32'hE0CE_0000;
   localparam logic [host_ctrl_pkg::ADDR_W-1:0] SO = host_ctrl_pkg::FLAGS_SET_OFS;
   localparam logic [host_ctrl_pkg::ADDR_W-1:0] CO = host_ctrl_pkg::FLAGS_CLR_OFS;
   logic core_clk, rst_n, wr_en, rd_en, eeprom_load, eeprom_permit, fetch_error, bus_reset;
   logic req_valid, req_rom_block, ack_valid_ff, ack_tardy_event_ff, rom_regs_update_ff;
   logic rom_serve_en_ff, byte_swap_en_ff, phy_enhance_en_ff, link_phy_enable_ff;
   logic buffered_write_en_ff, link_connected_ff, flush_ff, rd_pend, upd_pend, busy, upd_exp;
   logic [host_ctrl_pkg::ADDR_W-1:0] addr;
   logic [31:0] wdata, rdata_ff, flags, d;
   logic [3:0] ack_code_ff, ack_exp;
   logic [31:0] rd_q[$];
   logic [3:0] ack_q[$];
   logic upd_q[$];
   int failures, total_checks;

   host_ctrl_set_clear_reg #(.RESET_CYCLES(RST_CYC)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata_ff(rdata_ff), .eeprom_load(eeprom_load),
      .eeprom_permit(eeprom_permit), .fetch_error(fetch_error), .bus_reset(bus_reset),
      .req_valid(req_valid), .req_rom_block(req_rom_block), .ack_valid_ff(ack_valid_ff),
      .ack_code_ff(ack_code_ff), .ack_tardy_event_ff(ack_tardy_event_ff),
      .rom_regs_update_ff(rom_regs_update_ff), .rom_serve_en_ff(rom_serve_en_ff),
      .byte_swap_en_ff(byte_swap_en_ff), .phy_enhance_en_ff(phy_enhance_en_ff),
      .link_phy_enable_ff(link_phy_enable_ff), .buffered_write_en_ff(buffered_write_en_ff),
      .link_connected_ff(link_connected_ff), .flush_ff(flush_ff)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one bus cycle; the model notes what each request must produce
   task automatic step(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] dd, input logic rq, input logic rb,
                       input logic [3:0] ev);
      logic [31:0] s;
      @(posedge core_clk);
      wr_en <= w;
      rd_en <= r;
      addr <= a;
      wdata <= dd;
      req_valid <= rq;
      req_rom_block <= rb;
      {eeprom_permit, eeprom_load, fetch_error, bus_reset} <= ev;
      if (r) rd_q.push_back((a == SO || a == CO) ? (flags | {15'h0, busy, 16'h0}) : 32'h0);
      if (rq && !busy && flags[17])
         ack_q.push_back((rb && !flags[31]) ? host_ctrl_pkg::ACK_TYPE_ERROR :
                         flags[29] ? host_ctrl_pkg::ACK_TARDY : host_ctrl_pkg::ACK_PENDING);
      if (ev[0]) upd_q.push_back(flags[31]);
      if (w && !busy && a == SO) begin
         s = dd & SET_M;
         // bit 31 only while the link is still inactive
         if (flags[17]) s[31] = 1'b0;
         flags = flags | s;
      end
      if (w && !busy && a == CO) flags = flags & ~(dd & CLR_M);
      if (ev[1]) flags[31] = 1'b0;
      if (ev[2]) flags[23] = ev[3];
   endtask

   // steering outputs lag the flags by one cycle, hence the idle step first
   task automatic levels();
      step(0, 0, SO, 0, 0, 0, 0);
      @(negedge core_clk);
      chk(32'(byte_swap_en_ff), 32'(!flags[30]), "swap");
      chk(32'(rom_serve_en_ff), 32'(flags[31]), "rom serve");
      chk(32'(phy_enhance_en_ff), 32'(flags[22]), "enhance");
      chk(32'(link_phy_enable_ff), 32'(flags[19]), "link power");
      chk(32'(buffered_write_en_ff), 32'(flags[18]), "buffered write");
      chk(32'(link_connected_ff), 32'(flags[17] && !busy), "connected");
      chk(32'(flush_ff), 32'(busy), "flush");
   endtask

   always @(posedge core_clk) begin
      rd_pend <= rd_en;
      upd_pend <= bus_reset;
      if (rd_pend)
         chk(rdata_ff, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hX, "read");
      else if (rst_n === 1'b1)
         chk(rdata_ff, 32'h0, "idle rdata");
      if (ack_valid_ff === 1'b1) begin
         ack_exp = (ack_q.size() > 0) ? ack_q.pop_front() : 4'hX;
         chk(32'(ack_code_ff), 32'(ack_exp), "ack code");
         chk(32'(ack_tardy_event_ff), 32'(ack_exp == host_ctrl_pkg::ACK_TARDY), "tardy");
      end
      if (upd_pend === 1'b1) begin
         upd_exp = (upd_q.size() > 0) ? upd_q.pop_front() : 1'bx;
         chk(32'(rom_regs_update_ff), 32'(upd_exp), "rom update");
      end
   end

   initial begin
      {wr_en, rd_en, eeprom_load, eeprom_permit, fetch_error, bus_reset} = '0;
      {req_valid, req_rom_block, rd_pend, upd_pend, busy} = '0;
      addr = '0;
      wdata = '0;
      rst_n = 1'b0;
      flags = host_ctrl_pkg::FLAGS_RESET;
      failures = 0;
      total_checks = 0;
      void'($urandom(63994));
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      step(0, 1, SO, 0, 0, 0, 0);
      step(0, 1, CO, 0, 0, 0, 0);
      step(1, 0, 8'h58, 32'hFFFF_FFFF, 0, 0, 0);
      step(0, 1, 8'h58, 0, 0, 0, 0);
      levels();
      // no phy clock in this bench, so no settle wait after link power
      step(1, 0, SO, 32'hFFBE_FFFF, 0, 0, 0);
      step(0, 1, CO, 0, 0, 0, 0);
      levels();
      step(0, 0, SO, 0, 1, 1, 0);
      step(0, 0, SO, 0, 1, 0, 0);
      step(1, 0, CO, 32'h8000_0000, 0, 0, 0);
      step(1, 0, SO, 32'h8000_0000, 0, 0, 0);
      step(0, 1, SO, 0, 1, 1, 0);
      step(1, 0, CO, 32'h2000_0000, 0, 0, 4'h1);
      step(0, 0, SO, 0, 1, 0, 0);
      step(1, 0, CO, 32'h0002_0000, 0, 0, 0);
      step(0, 0, SO, 0, 1, 1, 0);
      step(1, 0, SO, 32'h8000_0000, 0, 0, 0);
      step(0, 1, SO, 0, 0, 0, 4'h1);
      step(0, 0, SO, 0, 0, 0, 4'h2);
      step(0, 1, CO, 0, 0, 0, 4'h4);
      step(0, 1, SO, 0, 0, 0, 4'hC);
      step(0, 1, SO, 0, 0, 0, 0);
      levels();
      repeat (60) begin
         d = $urandom() & 32'hFFFE_FFFF;
         // driver touches phy enhance only with permit and link both set
         if (!(flags[23] && flags[17])) d[22] = 1'b0;
         if (flags[17]) d[18] = 1'b0;
         step(1, 0, d[0] ? SO : CO, d, d[1], d[2], {d[3], d[4] & d[5], d[6] & d[7], d[8]});
         step(0, 1, d[9] ? SO : CO, 0, d[10], d[11], 0);
         levels();
      end
      step(1, 0, CO, 32'h0002_0000, 0, 0, 0);
      step(1, 0, SO, 32'h000E_0000, 0, 0, 0);
      step(1, 0, SO, 32'h0001_0000, 0, 0, 0);
      busy = 1'b1;
      flags = flags & 32'h0080_0000;
      step(0, 0, SO, 0, 0, 0, 0);
      step(0, 1, SO, 0, 0, 0, 0);
      step(0, 0, SO, 0, 1, 0, 0);
      levels();
      repeat (RST_CYC + 3) step(0, 0, SO, 0, 0, 0, 0);
      busy = 1'b0;
      step(0, 1, CO, 0, 0, 0, 0);
      levels();
      step(1, 0, SO, 32'h600E_0000, 0, 0, 0);
      // reset lands before the write is taken, so nothing of it survives
      @(negedge core_clk);
      rst_n = 1'b0;
      flags = host_ctrl_pkg::FLAGS_RESET;
      levels();
      rst_n = 1'b1;
      step(0, 1, CO, 0, 0, 0, 0);
      levels();
      // last read is only popped two edges after its strobe
      repeat (2) @(negedge core_clk);
      chk(32'(rd_q.size() + ack_q.size() + upd_q.size()), 32'h0, "pending");
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
